/* rtl/mdcc_top.sv */
// What this block does
// R1: reset clamps all channels, clears data registers
// R2: bipolar pairs share one three-way range field
// R3: supply fault forces bipolar channels to negative rail
// R4: loop bit clear: bipolar codes from host
// R5: loop bit set: bipolar codes from controller
// R6: controller codes limited by upper-limit registers
// R7: each auxiliary channel picks its own span
// R8: data registers hold 12-bit straight binary codes
// R9: host writes land in buffer register first
// R10: data register reads return active register
// R11: asynchronous channels copy buffer to active immediately
// R12: synchronous channels update on bit or pin trigger
// R13: clamping keeps buffer and active contents intact
// R14: data writes accepted while channel is clamped
// R15: clamp release drives output from active register
// R16: clamp register bit per pair and auxiliary
// R17: groups held by a high standby pin ignore software clamp writes
// R18: standby pins clamp masked groups, delayed release
// R19: effective clamp is OR of all sources
`timescale 1ns/10ps
module mdcc_top #(
   parameter int unsigned CODE_W = 12
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // serial register port
   input wire logic spi_cs_n_i,
   input wire logic spi_sclk_i,
   input wire logic spi_sdi_i,
   output logic spi_sdo_o,
   output logic spi_sdo_oe_o,
   // device pins
   input wire logic output_update_strobe_i,
   input wire logic standby_force_pin_one_i,
   input wire logic standby_force_pin_two_i,
   input wire logic alarm_active_i,
   input wire logic primary_positive_supply_fault_i,
   // closed-loop controller codes, same clock
   input wire logic [4*CODE_W-1:0] loop_code_i,
   input wire logic [3:0] loop_code_valid_i,
   // converter side
   output logic [8*CODE_W-1:0] dac_code_o,
   output logic [7:0] dac_clamp_o,
   output logic [3:0] negative_rail_clamp_o,
   output logic [7:0] dac_range_o,
   output logic closed_loop_en_o
);

   if (CODE_W != 12) begin : g_bad_width
      $error("mdcc_top: only 12-bit codes are supported");
   end

   // groups: 0 pair a, 1 pair b, 2..5 auxiliary channels
   function automatic int chan_group(input int ch);
      return (ch < 4) ? ch / 2 : ch - 2;
   endfunction : chan_group

   // pin synchronisers: first stage feeds only the second
   localparam int NSYNC = 8;
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] meta_q;
   logic [NSYNC-1:0] sync_q;
   logic sclk_prev_q;
   logic trig_prev_q;
   assign pin_raw = {primary_positive_supply_fault_i, alarm_active_i, standby_force_pin_two_i,
                     standby_force_pin_one_i, output_update_strobe_i, spi_sdi_i, spi_sclk_i, spi_cs_n_i};

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta_q <= 8'h01;
         sync_q <= 8'h01;
         sclk_prev_q <= 1'b0;
         trig_prev_q <= 1'b0;
      end else begin
         meta_q <= pin_raw;
         sync_q <= meta_q;
         sclk_prev_q <= sync_q[1];
         trig_prev_q <= sync_q[3];
      end
   end

   logic cs_act;
   logic sclk_rise;
   logic sclk_fall;
   logic sdi_s;
   logic pin_trig_rise;
   logic [1:0] stby_pin;
   logic alarm_s;
   logic fault_s;
   assign cs_act = ~sync_q[0];
   assign sclk_rise = sync_q[1] & ~sclk_prev_q;
   assign sclk_fall = ~sync_q[1] & sclk_prev_q;
   assign sdi_s = sync_q[2];
   assign pin_trig_rise = sync_q[3] & ~trig_prev_q;
   assign stby_pin = sync_q[5:4];
   assign alarm_s = sync_q[6];
   assign fault_s = sync_q[7];

   // serial frame engine
   mdcc_pkg::mdcc_spi_state_t state_q;
   logic [4:0] cnt_q;
   logic [15:0] sh_q;
   logic [7:0] hdr_q;
   logic [15:0] out_q;
   logic sdo_q;
   logic wr_q;
   logic [6:0] wr_addr_q;
   logic [15:0] wr_data_q;
   logic [6:0] rd_addr;
   logic [15:0] rd_data;
   logic [15:0] frame_data;
   assign rd_addr = {sh_q[5:0], sdi_s};
   assign frame_data = {sh_q[14:0], sdi_s};

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state_q <= mdcc_pkg::MDCC_SPI_IDLE;
         cnt_q <= 5'h00;
         sh_q <= 16'h0000;
         hdr_q <= 8'h00;
         out_q <= 16'h0000;
         sdo_q <= 1'b0;
         wr_q <= 1'b0;
         wr_addr_q <= 7'h00;
         wr_data_q <= 16'h0000;
      end else begin
         wr_q <= 1'b0;
         if (!cs_act) begin
            state_q <= mdcc_pkg::MDCC_SPI_IDLE;
            sdo_q <= 1'b0;
         end else begin
            case (state_q)
               mdcc_pkg::MDCC_SPI_IDLE: begin
                  state_q <= mdcc_pkg::MDCC_SPI_HDR;
                  cnt_q <= 5'h00;
               end
               mdcc_pkg::MDCC_SPI_HDR: begin
                  if (sclk_rise) begin
                     sh_q <= frame_data;
                     cnt_q <= cnt_q + 5'h01;
                     if (cnt_q == 5'(mdcc_pkg::MDCC_HDR_BITS - 1)) begin
                        hdr_q <= frame_data[7:0];
                        out_q <= rd_data;
                        cnt_q <= 5'h00;
                        state_q <= mdcc_pkg::MDCC_SPI_DATA;
                     end
                  end
               end
               mdcc_pkg::MDCC_SPI_DATA: begin
                  if (sclk_fall) begin
                     sdo_q <= out_q[15];
                     out_q <= {out_q[14:0], 1'b0};
                  end
                  if (sclk_rise) begin
                     sh_q <= frame_data;
                     cnt_q <= cnt_q + 5'h01;
                     if (cnt_q == 5'(mdcc_pkg::MDCC_DATA_BITS - 1)) begin
                        wr_q <= ~hdr_q[7];
                        wr_addr_q <= hdr_q[6:0];
                        wr_data_q <= frame_data;
                        state_q <= mdcc_pkg::MDCC_SPI_DONE;
                     end
                  end
               end
               default: begin
                  state_q <= mdcc_pkg::MDCC_SPI_DONE;
               end
            endcase
         end
      end
   end

   assign spi_sdo_o = sdo_q;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         spi_sdo_oe_o <= 1'b0;
      end else begin
         spi_sdo_oe_o <= cs_act;
      end
   end

   // control registers
   logic [7:0] cfg0_q;
   logic [7:0] sync_sel_q;
   logic [7:0] range_q;
   logic [5:0] sw_clamp_q;
   logic [7:0] stby_mask_q [2];
   logic [5:0] alarm_sel_q;
   logic [11:0] limit_q [2];
   logic [5:0] stby_hold_q [2];
   logic [5:0] alarm_hold_q;
   logic [5:0] clamp_q;
   logic [1:0] rail_q;

   logic wr_cfg0;
   logic wr_sync;
   logic wr_range;
   logic wr_clamp;
   logic wr_stby1;
   logic wr_stby2;
   logic wr_alarm;
   logic wr_lim0;
   logic wr_lim1;
   logic trig;
   logic [5:0] stby_lock;
   logic loop_en;
   assign wr_cfg0 = wr_q && (wr_addr_q == mdcc_pkg::MDCC_ADDR_CFG0);
   assign wr_sync = wr_q && (wr_addr_q == mdcc_pkg::MDCC_ADDR_SYNC);
   assign wr_range = wr_q && (wr_addr_q == mdcc_pkg::MDCC_ADDR_RANGE);
   assign wr_clamp = wr_q && (wr_addr_q == mdcc_pkg::MDCC_ADDR_CLAMP);
   assign wr_stby1 = wr_q && (wr_addr_q == mdcc_pkg::MDCC_ADDR_STBY1);
   assign wr_stby2 = wr_q && (wr_addr_q == mdcc_pkg::MDCC_ADDR_STBY2);
   assign wr_alarm = wr_q && (wr_addr_q == mdcc_pkg::MDCC_ADDR_ALARM);
   assign wr_lim0 = wr_q && (wr_addr_q == mdcc_pkg::MDCC_ADDR_LIM0);
   assign wr_lim1 = wr_q && (wr_addr_q == mdcc_pkg::MDCC_ADDR_LIM1);
   // trigger bit is a strobe, never stored
   assign trig = (wr_q && (wr_addr_q == mdcc_pkg::MDCC_ADDR_TRIG)
                  && wr_data_q[mdcc_pkg::MDCC_TRIG_BIT]) || pin_trig_rise; // see R12
   // groups currently forced by a high standby pin
   assign stby_lock = ({6{stby_pin[0]}} & stby_mask_q[0][5:0])
                    | ({6{stby_pin[1]}} & stby_mask_q[1][5:0]); // see R17
   assign loop_en = cfg0_q[mdcc_pkg::MDCC_CFG0_LOOP_BIT];

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cfg0_q <= mdcc_pkg::MDCC_RST_CFG0;
         sync_sel_q <= mdcc_pkg::MDCC_RST_SYNC;
         range_q <= mdcc_pkg::MDCC_RST_RANGE;
         sw_clamp_q <= mdcc_pkg::MDCC_RST_CLAMP; // see R1
         stby_mask_q[0] <= mdcc_pkg::MDCC_RST_MASK;
         stby_mask_q[1] <= mdcc_pkg::MDCC_RST_MASK;
         alarm_sel_q <= mdcc_pkg::MDCC_RST_MASK[5:0];
         limit_q[0] <= mdcc_pkg::MDCC_RST_LIMIT;
         limit_q[1] <= mdcc_pkg::MDCC_RST_LIMIT;
      end else begin
         if (wr_cfg0) cfg0_q <= wr_data_q[7:0];
         if (wr_sync) sync_sel_q <= wr_data_q[7:0];
         if (wr_range) range_q <= wr_data_q[7:0]; // see R2, R7
         // locked bits keep their value while the pin holds them
         if (wr_clamp) sw_clamp_q <= (sw_clamp_q & stby_lock) | (wr_data_q[5:0] & ~stby_lock); // see R16, R17
         if (wr_stby1) stby_mask_q[0] <= wr_data_q[7:0];
         if (wr_stby2) stby_mask_q[1] <= wr_data_q[7:0];
         if (wr_alarm) alarm_sel_q <= wr_data_q[5:0];
         if (wr_lim0) limit_q[0] <= wr_data_q[11:0];
         if (wr_lim1) limit_q[1] <= wr_data_q[11:0];
      end
   end

   // standby and alarm holds: a pin set wins over a clamp-register clear
   for (genvar p = 0; p < 2; p++) begin : g_stby
      logic [5:0] hold_d;
      assign hold_d = stby_pin[p] ? (stby_hold_q[p] | stby_mask_q[p][5:0])
                    : !stby_mask_q[p][mdcc_pkg::MDCC_DELAYED_RELEASE_BIT] ? 6'h00
                    : wr_clamp ? 6'h00 : stby_hold_q[p]; // see R18
      always_ff @(posedge clk_i) begin
         if (!rst_n_i) begin
            stby_hold_q[p] <= 6'h00;
         end else begin
            stby_hold_q[p] <= hold_d;
         end
      end
   end

   logic [5:0] alarm_hold_d;
   logic [5:0] clamp_d;
   // alarm clamp stays until software writes the clamp register
   assign alarm_hold_d = alarm_s ? (alarm_hold_q | alarm_sel_q) : (wr_clamp ? 6'h00 : alarm_hold_q);
   assign clamp_d = sw_clamp_q | stby_hold_q[0] | stby_hold_q[1] | alarm_hold_q; // see R19

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         alarm_hold_q <= 6'h00;
         clamp_q <= mdcc_pkg::MDCC_RST_CLAMP; // see R1
         rail_q <= 2'b00;
         dac_range_o <= mdcc_pkg::MDCC_RST_RANGE;
         closed_loop_en_o <= 1'b0;
      end else begin
         alarm_hold_q <= alarm_hold_d;
         clamp_q <= clamp_d; // see R13
         rail_q <= {2{fault_s}}; // see R3
         dac_range_o <= range_q;
         closed_loop_en_o <= loop_en;
      end
   end

   // per channel buffer and active registers
   logic [11:0] act_q [8];
   for (genvar i = 0; i < 8; i++) begin : g_ch
      logic [11:0] buf_q;
      logic host_wr;
      logic from_loop;
      assign host_wr = wr_q && (wr_addr_q == mdcc_pkg::MDCC_ADDR_DATA0 + 7'(i)); // see R14
      if (i < 4) begin : g_bip
         logic [11:0] req;
         assign req = loop_code_i[i*12 +: 12];
         assign from_loop = loop_en; // see R4, R5
         always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
               act_q[i] <= mdcc_pkg::MDCC_RST_CODE;
            end else if (from_loop) begin
               if (loop_code_valid_i[i]) begin
                  act_q[i] <= (req > limit_q[i/2]) ? limit_q[i/2] : req; // see R6
               end
            end else if (host_wr && !sync_sel_q[i]) begin
               act_q[i] <= wr_data_q[11:0]; // see R11
            end else if (trig && sync_sel_q[i]) begin
               act_q[i] <= buf_q; // see R12
            end
         end
      end else begin : g_aux
         assign from_loop = 1'b0;
         always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
               act_q[i] <= mdcc_pkg::MDCC_RST_CODE;
            end else if (host_wr && !sync_sel_q[i]) begin
               act_q[i] <= wr_data_q[11:0]; // see R11
            end else if (trig && sync_sel_q[i]) begin
               act_q[i] <= buf_q; // see R12
            end
         end
      end
      always_ff @(posedge clk_i) begin
         if (!rst_n_i) begin
            buf_q <= mdcc_pkg::MDCC_RST_CODE; // see R1
         end else if (host_wr) begin
            buf_q <= wr_data_q[11:0]; // see R8, R9
         end
      end
      // code output always shows active; clamp only overrides the analog side
      assign dac_code_o[i*12 +: 12] = act_q[i]; // see R15
      assign dac_clamp_o[i] = clamp_q[chan_group(i)];
   end

   for (genvar b = 0; b < 4; b++) begin : g_rail
      assign negative_rail_clamp_o[b] = rail_q[b/2]; // see R3
   end

   // read selection
   always_comb begin
      rd_data = 16'h0000;
      if (rd_addr == mdcc_pkg::MDCC_ADDR_CFG0) begin
         rd_data = {8'h00, cfg0_q};
      end else if (rd_addr == mdcc_pkg::MDCC_ADDR_SYNC) begin
         rd_data = {8'h00, sync_sel_q};
      end else if (rd_addr == mdcc_pkg::MDCC_ADDR_RANGE) begin
         rd_data = {8'h00, range_q};
      end else if (rd_addr == mdcc_pkg::MDCC_ADDR_CLAMP) begin
         rd_data = {10'h000, sw_clamp_q};
      end else if (rd_addr == mdcc_pkg::MDCC_ADDR_STBY1) begin
         rd_data = {8'h00, stby_mask_q[0]};
      end else if (rd_addr == mdcc_pkg::MDCC_ADDR_STBY2) begin
         rd_data = {8'h00, stby_mask_q[1]};
      end else if (rd_addr == mdcc_pkg::MDCC_ADDR_ALARM) begin
         rd_data = {10'h000, alarm_sel_q};
      end else if (rd_addr >= mdcc_pkg::MDCC_ADDR_DATA0 && rd_addr <= mdcc_pkg::MDCC_ADDR_DATA7) begin
         rd_data = {4'h0, act_q[rd_addr[2:0]]}; // see R10
      end else if (rd_addr == mdcc_pkg::MDCC_ADDR_LIM0) begin
         rd_data = {4'h0, limit_q[0]};
      end else if (rd_addr == mdcc_pkg::MDCC_ADDR_LIM1) begin
         rd_data = {4'h0, limit_q[1]};
      end
   end

endmodule : mdcc_top

/* pkg/mdcc_pkg.sv */
package mdcc_pkg;

   // register offsets (7-bit serial address space)
   localparam logic [6:0] MDCC_ADDR_CFG0 = 7'h10;
   localparam logic [6:0] MDCC_ADDR_SYNC = 7'h15;
   localparam logic [6:0] MDCC_ADDR_RANGE = 7'h16;
   localparam logic [6:0] MDCC_ADDR_CLAMP = 7'h17;
   localparam logic [6:0] MDCC_ADDR_STBY1 = 7'h18;
   localparam logic [6:0] MDCC_ADDR_STBY2 = 7'h19;
   localparam logic [6:0] MDCC_ADDR_ALARM = 7'h1A;
   localparam logic [6:0] MDCC_ADDR_TRIG = 7'h1C;
   localparam logic [6:0] MDCC_ADDR_DATA0 = 7'h30;
   localparam logic [6:0] MDCC_ADDR_DATA7 = 7'h37;
   localparam logic [6:0] MDCC_ADDR_LIM0 = 7'h4E;
   localparam logic [6:0] MDCC_ADDR_LIM1 = 7'h4F;

   // field positions
   localparam int MDCC_CFG0_LOOP_BIT = 0;
   localparam int MDCC_TRIG_BIT = 0;
   localparam int MDCC_DELAYED_RELEASE_BIT = 7;
   localparam int MDCC_RANGE_PAIR_A_LSB = 0;
   localparam int MDCC_RANGE_PAIR_B_LSB = 2;
   localparam int MDCC_RANGE_AUX_LSB = 4;

   // reset values
   localparam logic [7:0] MDCC_RST_CFG0 = 8'h00;
   localparam logic [7:0] MDCC_RST_SYNC = 8'h00;
   localparam logic [7:0] MDCC_RST_RANGE = 8'h00;
   localparam logic [5:0] MDCC_RST_CLAMP = 6'h3F;
   localparam logic [7:0] MDCC_RST_MASK = 8'h00;
   localparam logic [11:0] MDCC_RST_CODE = 12'h000;
   localparam logic [11:0] MDCC_RST_LIMIT = 12'hFFF;

   // bipolar pair range codes
   typedef enum logic [1:0] {
      MDCC_RANGE_0_TO_5 = 2'b00,
      MDCC_RANGE_M5_TO_0 = 2'b01,
      MDCC_RANGE_M4_TO_1 = 2'b10
   } mdcc_range_t;

   // serial frame: 1 read bit, 7 address bits, 16 data bits
   localparam int MDCC_HDR_BITS = 8;
   localparam int MDCC_DATA_BITS = 16;

   typedef enum logic [1:0] {
      MDCC_SPI_IDLE = 2'b00,
      MDCC_SPI_HDR = 2'b01,
      MDCC_SPI_DATA = 2'b10,
      MDCC_SPI_DONE = 2'b11
   } mdcc_spi_state_t;

endpackage : mdcc_pkg

/* verif/mdcc_top_checker.sv */
`timescale 1ns/10ps
module mdcc_top_checker #(
   parameter int unsigned CODE_W = 12
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // watched inputs
   input wire logic spi_cs_n_i,
   input wire logic output_update_strobe_i,
   input wire logic primary_positive_supply_fault_i,
   input wire logic [4*CODE_W-1:0] loop_code_i,
   input wire logic [3:0] loop_code_valid_i,
   // watched outputs
   input wire logic [8*CODE_W-1:0] dac_code_o,
   input wire logic [7:0] dac_clamp_o,
   input wire logic [3:0] negative_rail_clamp_o,
   input wire logic [7:0] dac_range_o,
   input wire logic closed_loop_en_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // cycles since frame select went high, saturating
   logic [3:0] cs_hi_q;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || !spi_cs_n_i) begin
         cs_hi_q <= 4'h0;
      end else if (cs_hi_q != 4'hF) begin
         cs_hi_q <= cs_hi_q + 4'h1;
      end
   end
   // long enough for a write or a pin trigger to have landed
   sequence s_quiet;
      (spi_cs_n_i && !output_update_strobe_i)[*8];
   endsequence
   sequence s_fault;
      primary_positive_supply_fault_i[*5];
   endsequence
   chk_reset_defaults: assert property ($rose(rst_n_i) |-> dac_clamp_o == 8'hFF && dac_code_o == '0)
      else $error("channels not clamped and cleared after reset");
   chk_rail_forced: assert property (s_fault |-> negative_rail_clamp_o == 4'hF)
      else $error("supply fault did not force rail clamp");
   chk_rail_free: assert property ((!primary_positive_supply_fault_i)[*5] |-> negative_rail_clamp_o == 4'h0)
      else $error("rail clamp without supply fault");
   chk_open_loop: assert property (s_quiet ##0 (!closed_loop_en_o && loop_code_valid_i[0]) |=> $stable(dac_code_o[11:0]))
      else $error("controller code used in open loop");
   chk_loop_limit: assert property (closed_loop_en_o && loop_code_valid_i[0] |-> ##2 dac_code_o[11:0] <= loop_code_i[11:0])
      else $error("closed loop code above request");
   chk_clamp_keeps: assert property ($rose(dac_clamp_o[0]) |-> $stable(dac_code_o[11:0]))
      else $error("clamp entry changed active code");
   chk_release_keeps: assert property ($fell(dac_clamp_o[4]) |-> $stable(dac_code_o[59:48]))
      else $error("clamp release changed active code");
   chk_range_frame: assert property ($changed(dac_range_o) |-> cs_hi_q < 4'hA)
      else $error("range changed without a frame");
endmodule : mdcc_top_checker

bind mdcc_top mdcc_top_checker #(.CODE_W(CODE_W)) u_chk (.clk_i, .rst_n_i, .spi_cs_n_i, .output_update_strobe_i,
   .primary_positive_supply_fault_i, .loop_code_i, .loop_code_valid_i, .dac_code_o, .dac_clamp_o,
   .negative_rail_clamp_o, .dac_range_o, .closed_loop_en_o);

/* verif/mdcc_host_model.sv */
`timescale 1ns/10ps
module mdcc_host_model (
   // control from bench
   input wire logic clk_i,
   input wire logic start_i,
   input wire logic rd_i,
   input wire logic [6:0] addr_i,
   input wire logic [15:0] wdata_i,
   // serial pins
   input wire logic spi_sdo_i,
   output logic spi_cs_n_o,
   output logic spi_sclk_o,
   output logic spi_sdi_o,
   // result
   output logic [15:0] rdata_o,
   output logic done_o
);
   logic [23:0] frame;
   initial begin
      spi_cs_n_o = 1'b1;
      spi_sclk_o = 1'b0;
      spi_sdi_o = 1'b0;
      rdata_o = '0;
      done_o = 1'b0;
   end
   // halves of 6 clk leave margin over the 4 clk sampling minimum
   always begin
      @(posedge clk_i iff start_i);
      done_o = 1'b0;
      frame = {rd_i, addr_i, wdata_i};
      @(negedge clk_i);
      spi_cs_n_o = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         spi_sdi_o = frame[i];
         repeat (6) @(negedge clk_i);
         spi_sclk_o = 1'b1;
         if (i < 16) begin
            rdata_o[i] = spi_sdo_i;
         end
         repeat (6) @(negedge clk_i);
         spi_sclk_o = 1'b0;
      end
      repeat (8) @(negedge clk_i);
      spi_cs_n_o = 1'b1;
      // released line must not keep showing the last bit
      spi_sdi_o = ~spi_sdi_o;
      repeat (6) @(negedge clk_i);
      done_o = 1'b1;
   end
endmodule : mdcc_host_model

/* verif/test_mdcc_top.sv */
`timescale 1ns/10ps
module test_mdcc_top;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic strobe = 1'b0, sb1 = 1'b0, sb2 = 1'b0, alarm = 1'b0, fault = 1'b0;
   logic [47:0] lcode = '0;
   logic [3:0] lvalid = '0;
   logic go = 1'b0, rd = 1'b0;
   logic [6:0] addr = '0;
   logic [15:0] wdata = '0;
   wire logic cs_n, sclk, sdi, sdo, sdo_oe, done, loop_en;
   wire logic [15:0] rdata;
   wire logic [95:0] code;
   wire logic [7:0] clamp, range;
   wire logic [3:0] rail;
   int n_errors = 0;
   int n_compared = 0;
   logic [31:0] seed = 32'h00000063;
   logic [15:0] expq[$];
   always #2 clk_i = ~clk_i;
   mdcc_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .spi_cs_n_i(cs_n), .spi_sclk_i(sclk), .spi_sdi_i(sdi),
      .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe), .output_update_strobe_i(strobe), .standby_force_pin_one_i(sb1),
      .standby_force_pin_two_i(sb2), .alarm_active_i(alarm), .primary_positive_supply_fault_i(fault),
      .loop_code_i(lcode), .loop_code_valid_i(lvalid), .dac_code_o(code), .dac_clamp_o(clamp),
      .negative_rail_clamp_o(rail), .dac_range_o(range), .closed_loop_en_o(loop_en));
   mdcc_host_model host (.clk_i(clk_i), .start_i(go), .rd_i(rd), .addr_i(addr), .wdata_i(wdata),
      .spi_sdo_i(sdo), .spi_cs_n_o(cs_n), .spi_sclk_o(sclk), .spi_sdi_o(sdi), .rdata_o(rdata), .done_o(done));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task automatic check(input logic [95:0] seen, input logic [95:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop
   task automatic xfer(input logic r, input logic [6:0] a, input logic [15:0] d);
      int i;
      @(negedge clk_i);
      rd = r;
      addr = a;
      wdata = d;
      go = 1'b1;
      @(negedge clk_i);
      go = 1'b0;
      // frame is still open here, so the reply driver must be enabled
      repeat (6) @(negedge clk_i);
      check(sdo_oe, 1'b1);
      for (i = 0; i < 2000 && !done; i++) @(posedge clk_i);
      if (!done) begin
         n_errors++;
         report_and_stop();
      end else begin
         check(sdo_oe, 1'b0);
         @(negedge clk_i);
      end
   endtask : xfer
   task automatic rdchk(input logic [6:0] a, input logic [15:0] exp);
      expq.push_back(exp);
      xfer(1'b1, a, 16'h0000);
   endtask : rdchk
   task automatic pin_wait();
      repeat (6) @(negedge clk_i);
   endtask : pin_wait
   task automatic pulse();
      lvalid = 4'h3;
      @(negedge clk_i);
      lvalid = 4'h0;
      repeat (4) @(negedge clk_i);
   endtask : pulse
   // read results arrive in request order
   always @(posedge done) begin
      if (rd) begin
         check(rdata, expq.pop_front());
      end
   end
   initial begin
      logic [11:0] v[8];
      repeat (6) @(negedge clk_i);
      rst_n_i = 1'b1;
      repeat (3) @(negedge clk_i);
      check(clamp, 8'hFF);
      check(code, '0);
      rdchk(mdcc_pkg::MDCC_ADDR_CLAMP, 16'h003F);
      rdchk(7'h7F, 16'h0000);
      for (int ch = 0; ch < 8; ch++) begin
         seed = xs(seed);
         v[ch] = seed[11:0];
         xfer(1'b0, mdcc_pkg::MDCC_ADDR_DATA0 + 7'(ch), {4'h0, v[ch]});
         rdchk(mdcc_pkg::MDCC_ADDR_DATA0 + 7'(ch), {4'h0, v[ch]});
         check(code[ch*12+:12], v[ch]);
      end
      xfer(1'b0, mdcc_pkg::MDCC_ADDR_CLAMP, 16'h0000);
      check(clamp, 8'h00);
      check(code[59:0], {v[4], v[3], v[2], v[1], v[0]});
      $display("test async and clamp done");
      xfer(1'b0, mdcc_pkg::MDCC_ADDR_SYNC, 16'h0003);
      xfer(1'b0, mdcc_pkg::MDCC_ADDR_DATA0, 16'h0111);
      rdchk(mdcc_pkg::MDCC_ADDR_DATA0, {4'h0, v[0]});
      xfer(1'b0, mdcc_pkg::MDCC_ADDR_TRIG, 16'h0001);
      rdchk(mdcc_pkg::MDCC_ADDR_DATA0, 16'h0111);
      xfer(1'b0, mdcc_pkg::MDCC_ADDR_DATA0 + 7'd1, 16'h0222);
      strobe = 1'b1;
      pin_wait();
      strobe = 1'b0;
      pin_wait();
      check(code[23:12], 12'h222);
      xfer(1'b0, mdcc_pkg::MDCC_ADDR_RANGE, 16'h0096);
      check(range, 8'h96);
      $display("test sync and range done");
      xfer(1'b0, mdcc_pkg::MDCC_ADDR_STBY1, 16'h0001);
      sb1 = 1'b1;
      pin_wait();
      check(clamp, 8'h03);
      xfer(1'b0, mdcc_pkg::MDCC_ADDR_CLAMP, 16'h0001);
      rdchk(mdcc_pkg::MDCC_ADDR_CLAMP, 16'h0000);
      sb1 = 1'b0;
      pin_wait();
      check(clamp, 8'h00);
      xfer(1'b0, mdcc_pkg::MDCC_ADDR_STBY2, 16'h0082);
      sb2 = 1'b1;
      pin_wait();
      sb2 = 1'b0;
      pin_wait();
      check(clamp, 8'h0C);
      xfer(1'b0, mdcc_pkg::MDCC_ADDR_ALARM, 16'h0020);
      alarm = 1'b1;
      pin_wait();
      alarm = 1'b0;
      pin_wait();
      check(clamp, 8'h8C);
      xfer(1'b0, mdcc_pkg::MDCC_ADDR_CLAMP, 16'h0000);
      check(clamp, 8'h00);
      fault = 1'b1;
      pin_wait();
      check(rail, 4'hF);
      fault = 1'b0;
      pin_wait();
      check(rail, 4'h0);
      $display("test clamp sources done");
      lcode = {24'h000000, 12'h123, 12'hA00};
      pulse();
      check(code[23:0], {12'h222, 12'h111});
      xfer(1'b0, mdcc_pkg::MDCC_ADDR_LIM0, 16'h0800);
      xfer(1'b0, mdcc_pkg::MDCC_ADDR_CFG0, 16'h0001);
      check(loop_en, 1'b1);
      pulse();
      check(code[23:0], {12'h123, 12'h800});
      rdchk(mdcc_pkg::MDCC_ADDR_DATA0, 16'h0800);
      $display("test closed loop done");
      report_and_stop();
   end
endmodule : test_mdcc_top
